//--- hw/flash_dev.sv
// Purpose: Flash device end: frame decode, page load, self-timed program
// Assumes: Extended protocol, opcode on lane 0; sclk runs only inside frames
// Notes: Frame logic on link sclk, array engine on ref_clk
// Notes on behaviour
// - Flag clear code resets all error flags
// - Host sends flag clear on protocol lanes
// - Flag clear ends on any chip-select rise
// - Host sets write enable before programming
// - Host holds select through last data bit
// - Unaligned end: no program, no flags
// - Address bits sampled on sclk rise
// - Locked sector: skip, keep latch, flag errors
// - Timeout clears latch, sets program error
// - Page program code; only ones become zeros
// - Dual input program codes accepted
// - Quad input program codes accepted
// - Busy bit high during program operation
// - Write enable latch cleared at end
// - Suspend pauses program, resume continues it
// - Unaligned start wraps within same page
// - Overlong data keeps last page bytes
// - Short data leaves other bytes untouched
// - Two-byte config data sent low first
`include "sfp_consts.svh"
`default_nettype none
module flash_dev
  import sfp_pkg::*;
#(
  parameter int PAGE = `PAGE_BYTES,
  parameter int ABYTES = `ADDR_BYTES,
  parameter int SEC_BITS = `SEC_BITS,
  parameter int MEM_BITS = `MEM_BITS,
  parameter int PP_CYC = `PP_CYC,
  parameter int NSEC = 1 << (8 * ABYTES - SEC_BITS)
) (
  input wire logic ref_clk,
  input wire logic resetn,
  sfp_if.dev link,
  input wire logic [NSEC-1:0] sector_lock,
  input wire logic fail_inject,
  input wire logic [MEM_BITS-1:0] rd_addr,
  output logic [7:0] rd_data,
  output logic wip,
  output logic wel,
  output logic err_prog,
  output logic err_prot,
  output logic err_erase,
  output logic suspended
);
  localparam int PW = $clog2(PAGE);
  localparam int AB = 8 * ABYTES;
  localparam int TW = $clog2(PP_CYC + 1);
  // Counters of the frame in progress, cleared while select is high
  typedef struct packed {
    ph_t ph;
    logic [5:0] left;
    logic [31:0] sh;
  } fr_t;
  // Results of the last frame, kept past the select rise for ref_clk
  typedef struct packed {
    logic [7:0] opc;
    logic [AB-1:0] adr;
    logic [PW-1:0] nbyte;
    logic any;
    logic aligned;
    logic id;
    logic [PAGE-1:0] mask;
    logic b1;
    logic b2;
  } res_t;
  typedef struct packed {
    core_st_t st;
    logic s1;
    logic s2;
    logic s2d;
    logic id_seen;
    logic wip;
    logic wel;
    logic err_prog;
    logic err_prot;
    logic err_erase;
    logic susp;
    logic [PW:0] idx;
    logic [TW-1:0] tmr;
    logic [7:0] rd;
  } core_t;
  localparam fr_t FR0 = '{ph: PH_OPC, left: 6'h08, sh: 32'h0};
  fr_t fr_reg, fr_next;
  res_t res_reg, res_next;
  core_t c_reg, c_next;
  logic [7:0] pbuf [PAGE];
  logic [7:0] mem [1 << MEM_BITS] = '{default: 8'hff}; // Powers up erased
  logic [2:0] w;
  logic [31:0] nsh;
  logic [5:0] nleft;
  logic buf_we;
  logic [PW-1:0] buf_idx;
  logic mem_we;
  logic [MEM_BITS-1:0] mem_a;
  logic [PW-1:0] pidx;
  logic sec_locked;
  // Device never drives the lanes: no read commands in this path
  assign link.dq_o_d = 4'h0;
  assign link.dq_oe_d = 4'h0;
  // Shift in one sclk edge worth of lanes
  always_comb begin
    fr_next = fr_reg;
    res_next = res_reg;
    buf_we = 1'b0;
    buf_idx = res_reg.adr[PW-1:0] + res_reg.nbyte; // Modulo page wrap
    res_next.b1 = c_reg.wip;
    res_next.b2 = res_reg.b1;
    unique case (fr_reg.ph)
      PH_ADR: w = addr_lanes(res_reg.opc);
      PH_DAT: w = data_lanes(res_reg.opc);
      default: w = 3'h1;
    endcase
    if (w == 3'h4) begin
      nsh = {fr_reg.sh[27:0], link.dq};
    end else if (w == 3'h2) begin
      nsh = {fr_reg.sh[29:0], link.dq[1:0]};
    end else begin
      nsh = {fr_reg.sh[30:0], link.dq[0]};
    end
    nleft = fr_reg.left - 6'(w);
    fr_next.sh = nsh;
    fr_next.left = nleft;
    res_next.aligned = (nleft == 6'h0); // Byte boundary tracking
    if (nleft == 6'h0) begin
      unique case (fr_reg.ph)
        PH_OPC: begin
          res_next.opc = nsh[7:0];
          res_next.id = ~res_reg.id;
          res_next.nbyte = '0;
          res_next.any = 1'b0;
          res_next.mask = res_reg.b2 ? res_reg.mask : '0; // Kept while the array engine reads it
          fr_next.ph = is_prog(nsh[7:0]) ? PH_ADR : PH_DAT;
          fr_next.left = is_prog(nsh[7:0]) ? 6'(AB) : 6'h08;
        end
        PH_ADR: begin
          res_next.adr = res_reg.b2 ? res_reg.adr : nsh[AB-1:0]; // Sampled on rising sclk
          fr_next.ph = PH_DAT;
          fr_next.left = 6'h08;
        end
        default: begin
          fr_next.left = 6'h08;
          // Later bytes overwrite earlier ones at the same slot
          if (is_prog(res_reg.opc) && !res_reg.b2) begin
            buf_we = 1'b1;
            res_next.mask[buf_idx] = 1'b1;
            res_next.nbyte = res_reg.nbyte + 1'b1;
            res_next.any = 1'b1;
          end
        end
      endcase
    end
  end
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      fr_reg <= FR0;
    end else begin
      fr_reg <= fr_next;
    end
  end

  always_ff @(posedge link.sclk or negedge resetn) begin
    if (!resetn) begin
      res_reg <= '0;
    end else begin
      res_reg <= res_next;
    end
  end

  // Page buffer; stable once select is high, so ref_clk may read it
  always_ff @(posedge link.sclk) begin
    if (buf_we) begin
      pbuf[buf_idx] <= fr_next.sh[7:0];
    end
  end

  // Array engine and status on ref_clk
  always_comb begin
    c_next = c_reg;
    c_next.s1 = link.cs_n;
    c_next.s2 = c_reg.s1;
    c_next.s2d = c_reg.s2;
    c_next.rd = mem[rd_addr];
    pidx = c_reg.idx[PW-1:0];
    mem_a = MEM_BITS'({res_reg.adr[AB-1:PW], pidx});
    mem_we = 1'b0;
    sec_locked = sector_lock[res_reg.adr[AB-1:SEC_BITS]];
    // Frame end seen on the synchronised select rise
    if (c_reg.s2 && !c_reg.s2d && res_reg.id != c_reg.id_seen) begin
      c_next.id_seen = res_reg.id;
      if (res_reg.opc == `OP_CLR_FLAG) begin
        c_next.err_prog = 1'b0; // Any bit count after opcode
        c_next.err_prot = 1'b0;
        c_next.err_erase = 1'b0;
      end else if (res_reg.opc == `OP_SUSPEND && c_reg.wip) begin
        c_next.susp = 1'b1;
      end else if (res_reg.opc == `OP_RESUME) begin
        c_next.susp = 1'b0;
      end else if (!c_reg.wip && res_reg.opc == `OP_WREN) begin
        c_next.wel = 1'b1;
      end else if (!c_reg.wip && is_prog(res_reg.opc) && c_reg.wel) begin
        // Requires the latch set first
        if (!res_reg.aligned || !res_reg.any) begin
          c_next.wel = 1'b1; // Not executed, no flags
        end else if (sec_locked) begin
          c_next.err_prot = 1'b1; // Skip, latch kept
          c_next.err_prog = 1'b1;
        end else begin
          c_next.st = ST_PROG;
          c_next.wip = 1'b1;
          c_next.idx = '0;
          c_next.tmr = '0;
        end
      end
    end
    if (c_reg.wip && !c_reg.susp) begin
      c_next.tmr = (c_reg.tmr == TW'(PP_CYC)) ? c_reg.tmr : c_reg.tmr + 1'b1;
    end
    unique case (c_reg.st)
      ST_PROG: begin
        if (!c_reg.susp) begin
          mem_we = res_reg.mask[pidx]; // Untouched bytes skipped
          c_next.idx = c_reg.idx + 1'b1;
          if (c_reg.idx == (PW + 1)'(PAGE - 1)) begin
            c_next.st = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (c_reg.tmr == TW'(PP_CYC)) begin
          c_next.st = ST_IDLE;
          c_next.wip = 1'b0;
          c_next.wel = 1'b0; // Success or not
          c_next.susp = 1'b0;
          if (fail_inject) begin
            c_next.err_prog = 1'b1; // Timed out
          end
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      c_reg <= '{st: ST_IDLE, s1: 1'b1, s2: 1'b1, s2d: 1'b1, default: '0};
    end else begin
      c_reg <= c_next;
    end
  end

  // Only ones can become zeros
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[mem_a] <= mem[mem_a] & pbuf[pidx];
    end
  end

  assign rd_data = c_reg.rd;
  assign wip = c_reg.wip;
  assign wel = c_reg.wel;
  assign err_prog = c_reg.err_prog;
  assign err_prot = c_reg.err_prot;
  assign err_erase = c_reg.err_erase;
  assign suspended = c_reg.susp;
endmodule
`default_nettype wire

//--- hw/flash_host.sv
// Purpose: Host end: frames one command onto the link per start pulse
// Assumes: sclk divided from ref_clk, data changes on falling sclk
// Notes: Extra clocks after the frame can force a misaligned end
`include "sfp_consts.svh"
`default_nettype none
module flash_host
  import sfp_pkg::*;
#(
  parameter int ABYTES = `ADDR_BYTES,
  parameter int HALF = `SCLK_HALF
) (
  input wire logic ref_clk,
  input wire logic resetn,
  sfp_if.host link,
  input wire logic start,
  input wire logic [7:0] code,
  input wire logic [8*ABYTES-1:0] addr,
  input wire logic [9:0] nbytes,
  input wire logic [2:0] xbits,
  input wire logic [7:0] wr_byte,
  output logic byte_taken,
  output logic busy
);
  localparam int AB = 8 * ABYTES;

  typedef struct packed {
    host_st_t st;
    logic [3:0] dv;
    logic sclk;
    logic cs_n;
    ph_t ph;
    logic [5:0] left;
    logic [31:0] sh;
    logic [2:0] w;
    logic [9:0] nb;
    logic [2:0] xb;
    logic [7:0] code;
    logic [3:0] dq;
    logic [3:0] oe;
    logic taken;
    logic busy;
  } h_t;

  h_t h_reg, h_next;
  logic [31:0] ssh;
  logic [5:0] sleft;

  // Divider, shifter and phase sequencing
  always_comb begin
    h_next = h_reg;
    h_next.taken = 1'b0;
    ssh = h_reg.sh << h_reg.w;
    sleft = h_reg.left - 6'(h_reg.w);
    unique case (h_reg.st)
      HS_IDLE: begin
        if (start) begin
          h_next = '{st: HS_RUN, cs_n: 1'b0, ph: PH_OPC, left: 6'h08, sh: {code, 24'h0}, w: 3'h1,
                     nb: nbytes, xb: xbits, code: code, busy: 1'b1, default: '0};
        end
      end
      HS_RUN: begin
        h_next.dv = h_reg.dv + 1'b1;
        if (h_reg.dv == 4'(HALF - 1)) begin
          h_next.dv = 4'h0;
          h_next.sclk = ~h_reg.sclk;
          // Shift only on the falling edge so the device's rise sees stable lanes
          if (h_reg.sclk) begin
            h_next.sh = ssh;
            h_next.left = sleft;
            if (sleft == 6'h0) begin
              if (h_reg.ph == PH_OPC && is_prog(h_reg.code)) begin
                h_next.ph = PH_ADR; // relies on a prior write-enable frame
                h_next.sh = {addr, (32 - AB)'(0)};
                h_next.left = 6'(AB);
                h_next.w = addr_lanes(h_reg.code);
              end else if (h_reg.ph != PH_XTR && h_reg.ph != PH_OPC && h_reg.nb != 10'h0) begin
                h_next.ph = PH_DAT;
                h_next.sh = {wr_byte, 24'h0};
                h_next.left = 6'h08;
                h_next.w = data_lanes(h_reg.code);
                h_next.nb = h_reg.nb - 1'b1;
                h_next.taken = 1'b1; // Feed order kept, so a two-byte value goes low byte first
              end else if (h_reg.ph != PH_XTR && h_reg.xb != 3'h0) begin
                h_next.ph = PH_XTR;
                h_next.sh = 32'h0;
                h_next.left = 6'(h_reg.xb);
                h_next.w = 3'h1;
              end else begin
                h_next.st = HS_GAP; // Select rises after the last bit
                h_next.cs_n = 1'b1;
              end
            end
          end
        end
      end
      HS_GAP: begin
        h_next.dv = h_reg.dv + 1'b1;
        if (h_reg.dv == 4'(`GAP_CYC)) begin
          h_next.st = HS_IDLE;
          h_next.busy = 1'b0;
          h_next.dv = 4'h0;
        end
      end
      default: h_next.st = HS_IDLE;
    endcase
    // Lanes per current width
    if (h_next.cs_n) begin
      h_next.oe = 4'h0;
      h_next.dq = 4'h0;
    end else if (h_next.w == 3'h4) begin
      h_next.oe = 4'hf;
      h_next.dq = h_next.sh[31:28];
    end else if (h_next.w == 3'h2) begin
      h_next.oe = 4'h3;
      h_next.dq = {2'h0, h_next.sh[31:30]};
    end else begin
      h_next.oe = 4'h1;
      h_next.dq = {3'h0, h_next.sh[31]};
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      h_reg <= '{st: HS_IDLE, cs_n: 1'b1, ph: PH_OPC, default: '0};
    end else begin
      h_reg <= h_next;
    end
  end

  assign link.sclk = h_reg.sclk;
  assign link.cs_n = h_reg.cs_n;
  assign link.dq_o_h = h_reg.dq;
  assign link.dq_oe_h = h_reg.oe;
  assign byte_taken = h_reg.taken;
  assign busy = h_reg.busy;
endmodule
`default_nettype wire

//--- hw/sfp_consts.svh
// Purpose: Shared constants for the serial flash program path
// Assumes: Included by the package and both link ends
// Notes: Opcodes, geometry and timing counts
`ifndef SFP_CONSTS_SVH
`define SFP_CONSTS_SVH
`define OP_CLR_FLAG 8'h50
`define OP_WREN 8'h06
`define OP_PP 8'h02
`define OP_DIFP 8'ha2
`define OP_XDIFP 8'hd2
`define OP_QIFP 8'h32
`define OP_XQIFP 8'h38
`define OP_SUSPEND 8'hb0
`define OP_RESUME 8'h7a
`define PAGE_BYTES 256
`define ADDR_BYTES 3
`define SEC_BITS 16
`define MEM_BITS 12
`define REF_PERIOD_NS 10
`define PP_TIME_NS 50000
`define PP_CYC ((`PP_TIME_NS + `REF_PERIOD_NS - 1) / `REF_PERIOD_NS)
`define SCLK_HALF 3
`define GAP_CYC 4
`endif

//--- hw/sfp_if.sv
// Purpose: Link between host controller and flash device
// Assumes: Pulled-up data lanes when nobody drives
// Notes: Wire level resolved here from the enables
`default_nettype none
interface sfp_if;
  logic sclk;
  logic cs_n;
  logic [3:0] dq_o_h;
  logic [3:0] dq_oe_h;
  logic [3:0] dq_o_d;
  logic [3:0] dq_oe_d;
  wire [3:0] dq;
  // Undriven lanes float high
  assign dq = (dq_oe_h & dq_o_h) | (dq_oe_d & dq_o_d) | ~(dq_oe_h | dq_oe_d);
  modport host(output sclk, output cs_n, output dq_o_h, output dq_oe_h, input dq);
  modport dev(input sclk, input cs_n, input dq, output dq_o_d, output dq_oe_d);
endinterface
`default_nettype wire

//--- hw/sfp_pkg.sv
// Purpose: Types and opcode helpers for the serial flash program path
// Assumes: sfp_consts.svh
// Notes: Lane widths are 1, 2 or 4
`include "sfp_consts.svh"
`default_nettype none
package sfp_pkg;
  typedef enum logic [3:0] {PH_OPC = 4'h1, PH_ADR = 4'h2, PH_DAT = 4'h4, PH_XTR = 4'h8} ph_t;
  typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_PROG = 3'h2, ST_WAIT = 3'h4} core_st_t;
  typedef enum logic [2:0] {HS_IDLE = 3'h1, HS_RUN = 3'h2, HS_GAP = 3'h4} host_st_t;

  function automatic logic is_prog(input logic [7:0] c);
    return c == `OP_PP || c == `OP_DIFP || c == `OP_XDIFP || c == `OP_QIFP || c == `OP_XQIFP;
  endfunction

  function automatic logic [2:0] addr_lanes(input logic [7:0] c);
    if (c == `OP_XDIFP) return 3'h2;
    if (c == `OP_XQIFP) return 3'h4;
    return 3'h1;
  endfunction

  function automatic logic [2:0] data_lanes(input logic [7:0] c);
    if (c == `OP_DIFP || c == `OP_XDIFP) return 3'h2;
    if (c == `OP_QIFP || c == `OP_XQIFP) return 3'h4;
    return 3'h1;
  endfunction
endpackage
`default_nettype wire

//--- testbench/sfp_asserts.sv
// Purpose: Link framing and status checks for the flash program path
// Assumes: One ref_clk domain; sclk is made from ref_clk by the host
// Notes: Counters bound the self-timed phases instead of long repeats
`default_nettype none
module sfp_asserts #(
  parameter int PP_CYC = 300
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] dq_oe_h,
  input wire logic [3:0] dq_oe_d,
  input wire logic busy,
  input wire logic wip,
  input wire logic wel,
  input wire logic err_prog,
  input wire logic err_prot,
  input wire logic suspended
);
  timeunit 1ns;
  timeprecision 1ps;
  // Slack for sync stages at both ends of the busy time
  localparam int WIP_MIN = PP_CYC - 4;
  int wip_cnt;
  int hi_cnt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Busy length and time since select went high
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wip_cnt <= 0;
      hi_cnt <= 0;
    end else begin
      wip_cnt <= wip ? wip_cnt + 1 : 0;
      hi_cnt <= !cs_n ? 0 : (hi_cnt < 15 ? hi_cnt + 1 : hi_cnt);
    end
  end
  sequence frame_open;
    $fell(cs_n);
  endsequence
  sequence first_rise;
    !sclk [*2] ##[1:2] sclk;
  endsequence
  a_first_rise: assert property (frame_open |-> first_rise) else $error("sclk start late");
  a_idle_clk_low: assert property (cs_n && $past(cs_n) |-> !sclk) else $error("sclk idle");
  a_idle_lanes: assert property (cs_n |-> dq_oe_h == 4'h0) else $error("host lanes idle");
  a_dev_lanes_off: assert property (dq_oe_d == 4'h0) else $error("device drives");
  a_busy_frame: assert property (!cs_n |-> busy) else $error("frame outside busy");
  a_wip_start: assert property ($rose(wip) |-> wel && hi_cnt inside {[2:8]}) else $error("wip start");
  a_wip_length: assert property ($fell(wip) |-> wip_cnt >= WIP_MIN) else $error("wip short");
  a_end_clears_wel: assert property ($fell(wip) |-> !wel) else $error("wel after end");
  a_prot_flags: assert property ($rose(err_prot) |-> err_prog && wel && !wip) else $error("prot flags");
  a_susp_wip: assert property (suspended |-> wip) else $error("suspend idle");
endmodule
`default_nettype wire

//--- testbench/tb_serial_flash_program_ops.sv
// Purpose: End-to-end bench, host end framing commands into the device end
// Assumes: Program time shortened to 300 cycles
// Notes: Array contents checked through the backdoor read port
`include "sfp_consts.svh"
`default_nettype none
`define chk(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; $display("[FAIL] %s exp=%0h got=%0h", nm, e, g); end end
module tb_serial_flash_program_ops
  import sfp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PP = 300;
  logic ref_clk, resetn, start, byte_taken, busy, fail_inject;
  logic wip, wel, err_prog, err_prot, err_erase, suspended;
  logic [7:0] code, wr_byte, base, rd_data;
  logic [23:0] addr;
  logic [9:0] nbytes, idx;
  logic [2:0] xbits;
  logic [255:0] sector_lock;
  logic [11:0] rd_addr;
  logic [7:0] codes [4] = '{`OP_DIFP, `OP_XDIFP, `OP_QIFP, `OP_XQIFP};
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  sfp_if link();
  flash_host u_flash_host (.ref_clk(ref_clk), .resetn(resetn), .link(link), .start(start), .code(code),
    .addr(addr), .nbytes(nbytes), .xbits(xbits), .wr_byte(wr_byte), .byte_taken(byte_taken), .busy(busy));
  flash_dev #(.PP_CYC(PP)) u_flash_dev (.ref_clk(ref_clk), .resetn(resetn), .link(link),
    .sector_lock(sector_lock), .fail_inject(fail_inject), .rd_addr(rd_addr), .rd_data(rd_data), .wip(wip),
    .wel(wel), .err_prog(err_prog), .err_prot(err_prot), .err_erase(err_erase), .suspended(suspended));
  sfp_asserts #(.PP_CYC(PP)) u_sfp_asserts (.ref_clk(ref_clk), .resetn(resetn), .sclk(link.sclk),
    .cs_n(link.cs_n), .dq_oe_h(link.dq_oe_h), .dq_oe_d(link.dq_oe_d), .busy(busy), .wip(wip), .wel(wel),
    .err_prog(err_prog), .err_prot(err_prot), .suspended(suspended));
  // Bytes past one page switch to a marker so overflow is visible
  function automatic logic [7:0] dbyte(input logic [9:0] i);
    return (i >= 10'h100) ? 8'h0f : base + i[7:0];
  endfunction
  task automatic conclude();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One frame per call; returns once status has settled
  task automatic cmd(input logic [7:0] c, input logic [23:0] a, input logic [9:0] n, input logic [2:0] x,
    input logic [7:0] s);
    int k;
    @(posedge ref_clk);
    code <= c;
    addr <= a;
    nbytes <= n;
    xbits <= x;
    base <= s;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    @(posedge ref_clk);
    k = 0;
    while (busy !== 1'b0 && k < 20000) begin
      @(posedge ref_clk);
      k++;
    end
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic idle();
    int k;
    k = 0;
    while (wip !== 1'b0 && k < 1000) begin
      @(posedge ref_clk);
      k++;
    end
  endtask
  task automatic prog(input logic [7:0] c, input logic [23:0] a, input logic [9:0] n, input logic [7:0] s);
    cmd(`OP_WREN, 24'h0, 10'h0, 3'h0, 8'h00);
    cmd(c, a, n, 3'h0, s);
    `chk("wip", 1'b1, wip)
    idle();
    `chk("wel", 1'b0, wel)
  endtask
  task automatic peek(input logic [11:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    rd_addr <= a;
    repeat (2) @(posedge ref_clk);
    `chk("mem", e, rd_data)
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Data feed on each taken byte, plus the hang limit
  always @(posedge ref_clk) begin
    if (!resetn) begin
      wr_byte <= 8'h00;
      idx <= 10'h000;
    end else if (start === 1'b1) begin
      wr_byte <= base;
      idx <= 10'h001;
    end else if (byte_taken === 1'b1) begin
      wr_byte <= dbyte(idx);
      idx <= idx + 10'h001;
    end
    cycles++;
    if (cycles == 60000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    resetn = 1'b0;
    start = 1'b0;
    code = 8'h00;
    addr = 24'h0;
    nbytes = 10'h0;
    xbits = 3'h0;
    base = 8'h00;
    sector_lock = 256'h0;
    fail_inject = 1'b0;
    rd_addr = 12'h0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    // Program with the latch clear is ignored
    cmd(`OP_PP, 24'h000020, 10'h002, 3'h0, 8'h11);
    `chk("wip", 1'b0, wip)
    peek(12'h020, 8'hff);
    // Short page program leaves neighbours alone
    prog(`OP_PP, 24'h000010, 10'h004, 8'h3c);
    for (int i = 0; i < 4; i++) peek(12'(16 + i), 8'(60 + i));
    peek(12'h00f, 8'hff);
    peek(12'h014, 8'hff);
    // A second pass can only clear bits
    prog(`OP_PP, 24'h000010, 10'h001, 8'hc3);
    peek(12'h010, 8'h00);
    // Every multi-lane program code
    foreach (codes[i]) begin
      prog(codes[i], 24'(256 + 16 * i), 10'h002, 8'(64 + 16 * i));
      peek(12'(256 + 16 * i), 8'(64 + 16 * i));
      peek(12'(257 + 16 * i), 8'(65 + 16 * i));
    end
    // Start near the page end wraps to the page start
    prog(`OP_PP, 24'h0002fe, 10'h004, 8'h80);
    peek(12'h2ff, 8'h81);
    peek(12'h200, 8'h82);
    peek(12'h300, 8'hff);
    // Two bytes past a full page: the last page wins
    prog(`OP_PP, 24'h000300, 10'h102, 8'h20);
    peek(12'h301, 8'h0f);
    peek(12'h302, 8'h22);
    peek(12'h3ff, 8'h1f);
    // Extra clocks after the last byte abort the program
    cmd(`OP_WREN, 24'h0, 10'h0, 3'h0, 8'h00);
    cmd(`OP_PP, 24'h000400, 10'h001, 3'h3, 8'h00);
    `chk("wip", 1'b0, wip)
    `chk("wel", 1'b1, wel)
    `chk("err", 1'b0, err_prog | err_prot)
    peek(12'h400, 8'hff);
    // Locked sector: skipped, both flags, latch kept
    sector_lock <= 256'h2;
    cmd(`OP_PP, 24'h010600, 10'h001, 3'h0, 8'h00);
    `chk("prot", 1'b1, err_prot)
    `chk("prog", 1'b1, err_prog)
    `chk("wel", 1'b1, wel)
    peek(12'h600, 8'hff);
    // Flag clear ended on a ragged bit count
    cmd(`OP_CLR_FLAG, 24'h0, 10'h0, 3'h5, 8'h00);
    `chk("prot", 1'b0, err_prot)
    `chk("prog", 1'b0, err_prog)
    `chk("erase", 1'b0, err_erase)
    // Timeout at completion sets the program error
    fail_inject <= 1'b1;
    prog(`OP_PP, 24'h000700, 10'h001, 8'h00);
    `chk("prog", 1'b1, err_prog)
    fail_inject <= 1'b0;
    // Suspend holds the operation, resume finishes it
    cmd(`OP_WREN, 24'h0, 10'h0, 3'h0, 8'h00);
    cmd(`OP_PP, 24'h0008f0, 10'h001, 3'h0, 8'h00);
    cmd(`OP_SUSPEND, 24'h0, 10'h0, 3'h0, 8'h00);
    `chk("susp", 1'b1, suspended)
    repeat (400) @(posedge ref_clk);
    `chk("wip", 1'b1, wip)
    cmd(`OP_RESUME, 24'h0, 10'h0, 3'h0, 8'h00);
    `chk("susp", 1'b0, suspended)
    idle();
    `chk("wip", 1'b0, wip)
    peek(12'h8f0, 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
